// ### logic/qpd_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time, fixed latency.
// Assumes a single aclk domain; register decode lives in the parent.
`timescale 1ns/10ps
`default_nettype none
module qpd_axil_slave
    import qpd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [QPD_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [QPD_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [QPD_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [QPD_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_go,
    output logic [QPD_AW-1:0] wr_addr,
    output logic [QPD_DW-1:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [QPD_AW-1:0] rd_addr,
    input wire logic [QPD_DW-1:0] rd_data,
    input wire logic rd_ok
);
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [QPD_AW-1:0] awaddr;
        logic [QPD_DW-1:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [QPD_DW-1:0] rdata;
        logic [1:0] rresp;
    } qpd_bus_s;
    qpd_bus_s st_ff;
    qpd_bus_s nxt_st;

    // Address and data captured in either order; response after both
    always_comb
    begin
        nxt_st = st_ff;
        wr_go = 1'b0;
        if (s_axi_awvalid & s_axi_awready)
        begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready)
        begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (st_ff.aw_got & st_ff.w_got & !st_ff.bvalid)
        begin
            wr_go = 1'b1;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = wr_ok ? QPD_RESP_OKAY : QPD_RESP_SLVERR;
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
        end
        if (st_ff.bvalid & s_axi_bready)
            nxt_st.bvalid = 1'b0;
        if (s_axi_arvalid & s_axi_arready)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = rd_ok ? rd_data : '0;
            nxt_st.rresp = rd_ok ? QPD_RESP_OKAY : QPD_RESP_SLVERR;
        end
        else if (st_ff.rvalid & s_axi_rready)
            nxt_st.rvalid = 1'b0;
    end

    // Ready is held off until the previous response has gone
    assign s_axi_awready = !st_ff.aw_got & !st_ff.bvalid;
    assign s_axi_wready = !st_ff.w_got & !st_ff.bvalid;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign wr_addr = st_ff.awaddr;
    assign wr_data = st_ff.wdata;
    assign wr_strb = st_ff.wstrb;
    assign rd_addr = s_axi_araddr;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end
endmodule
`default_nettype wire

// ### logic/qpd_edge_decode.sv
// Edge decoder: turns channel samples into step, direction and phase error pulses.
// Assumes channel inputs are already synchronous to aclk.
`timescale 1ns/10ps
`default_nettype none
module qpd_edge_decode
    import qpd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic enable,
    input wire logic count_both_channels,
    input wire logic step_direction_input_mode,
    input wire logic channel_exchange_on,
    input wire logic channel_a_in,
    input wire logic channel_b_in,
    output logic step,
    output logic step_reverse,
    output logic phase_error
);
    typedef struct packed {
        logic a;
        logic b;
    } qpd_dec_s;
    qpd_dec_s st_ff;
    qpd_dec_s nxt_st;
    logic a_w;
    logic b_w;
    logic a_edge;
    logic b_edge;

    // Exchange before any decoding, in both input modes
    assign a_w = channel_exchange_on ? channel_b_in : channel_a_in;
    assign b_w = channel_exchange_on ? channel_a_in : channel_b_in;
    assign a_edge = a_w ^ st_ff.a;
    assign b_edge = b_w ^ st_ff.b;

    // Decode; nothing fires while disabled
    always_comb
    begin
        nxt_st.a = a_w;
        nxt_st.b = b_w;
        step = 1'b0;
        step_reverse = 1'b0;
        phase_error = 1'b0;
        if (enable)
        begin
            if (step_direction_input_mode)
            begin
                // Rising clock edge is a step, level on B is sense
                step = a_edge & a_w;
                step_reverse = b_w;
            end
            else if (a_edge & b_edge)
            begin
                phase_error = 1'b1;
            end
            else
            begin
                step = a_edge | (b_edge & count_both_channels);
                // A leads B is forward: after an A edge, A differs from B
                step_reverse = a_edge ? (a_w == b_w) : (a_w != b_w);
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end
endmodule
`default_nettype wire

// ### logic/qpd_pkg.sv
// Package for the quadrature position decoder: register map, field layout, widths.
// Assumes a 32-bit AXI4-Lite register bus on one clock.
package qpd_pkg;
    localparam int QPD_DW = 32;
    localparam int QPD_AW = 8;
    // Register byte offsets
    localparam logic [7:0] QPD_CTRL_OFS = 8'h00;
    localparam logic [7:0] QPD_LIMIT_OFS = 8'h04;
    localparam logic [7:0] QPD_POS_OFS = 8'h08;
    localparam logic [7:0] QPD_STAT_OFS = 8'h0C;
    localparam logic [7:0] QPD_RAW_OFS = 8'h10;
    localparam logic [7:0] QPD_MASKED_OFS = 8'h14;
    localparam logic [7:0] QPD_IMASK_OFS = 8'h18;
    localparam logic [7:0] QPD_ICLR_OFS = 8'h1C;
    // Control fields
    localparam int QPD_CTRL_EN = 0;
    localparam int QPD_CTRL_BOTH = 1;
    localparam int QPD_CTRL_IDXRST = 2;
    localparam int QPD_CTRL_STEPDIR = 3;
    localparam int QPD_CTRL_SWAP = 4;
    localparam int QPD_CTRL_W = 5;
    // Interrupt bit positions
    localparam int QPD_IRQ_ERR = 0;
    localparam int QPD_IRQ_DIR = 1;
    localparam int QPD_IRQ_TMR = 2;
    localparam int QPD_IRQ_IDX = 3;
    localparam int QPD_IRQ_W = 4;
    // Status fields
    localparam int QPD_STAT_ERR = 0;
    localparam int QPD_STAT_REV = 1;
    localparam logic [31:0] QPD_DIR_FWD = 32'h0000_0001;
    localparam logic [31:0] QPD_DIR_REV = 32'hFFFF_FFFF;
    localparam logic [1:0] QPD_RESP_OKAY = 2'h0;
    localparam logic [1:0] QPD_RESP_SLVERR = 2'h2;
endpackage

// ### logic/qpd_top.sv
// Quadrature position decoder with AXI4-Lite registers and one interrupt line.
// Assumes encoder inputs synchronous to aclk; velocity timer expiry arrives as a pulse.
//
// Functional notes
// - Option counts edges of channel A only, or of both channels.
// - Option lets index pulse reset the position; off means index leaves position unchanged.
// - Option picks quadrature inputs or step clock plus direction level.
// - Option exchanges both channel inputs before any decoding.
// - In reset mode limit bounds position and a reverse index loads the limit.
// - Enable starts decoding; clearing it stops all decoding.
// - Direction reads as status bit 1: 0 forward, 1 reverse, held after motion stops.
// - Error flag sets when both quadrature inputs change together.
// - Interrupt status has error, direction, timer and index bits.
// - Each source has a mask bit; only enabled ones drive the interrupt.
// - Raw and masked status readable; masked is raw AND mask.
// - Writing a clear mask clears selected sources until they recur.
// - Position readable anytime; unaligned until first index in reset mode.
// - Sources raise on index, timer expiry, direction change, phase error.
// - Direction from edge order in quadrature; from level in step mode.
// - Without index reset the position is relative, never index-reset.
// - Velocity timer events count only while decoding is enabled.
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module qpd_top
    import qpd_pkg::*;
#(
    parameter int POS_W = 32
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic channel_a_in,
    input wire logic channel_b_in,
    input wire logic index_in,
    input wire logic velocity_timer_expired,
    output logic velocity_step,
    output logic irq,
    input wire logic [QPD_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [QPD_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [QPD_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [QPD_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef struct packed {
        logic [QPD_CTRL_W-1:0] ctrl;
        logic [POS_W-1:0] limit;
        logic [POS_W-1:0] pos;
        logic err;
        logic rev;
        logic [QPD_IRQ_W-1:0] raw;
        logic [QPD_IRQ_W-1:0] mask;
        logic idx_prev;
        logic irq;
        logic vstep;
    } qpd_top_s;
    qpd_top_s st_ff;
    qpd_top_s nxt_st;

    logic step;
    logic step_reverse;
    logic phase_error;
    logic wr_go;
    logic [QPD_AW-1:0] wr_addr;
    logic [QPD_DW-1:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [QPD_AW-1:0] rd_addr;
    logic [QPD_DW-1:0] rd_data;
    logic rd_ok;
    logic enable;
    logic idx_rise;
    logic [QPD_IRQ_W-1:0] events;

    // Byte-lane merge, used for every writable register except the clear register
    function automatic logic [QPD_DW-1:0] lane_merge(input logic [QPD_DW-1:0] old_v,
        input logic [QPD_DW-1:0] new_v, input logic [3:0] strb);
        logic [QPD_DW-1:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[i*8 +: 8] = new_v[i*8 +: 8];
        return r;
    endfunction

    assign enable = st_ff.ctrl[QPD_CTRL_EN];

    qpd_edge_decode u_dec (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(enable),
        .count_both_channels(st_ff.ctrl[QPD_CTRL_BOTH]),
        .step_direction_input_mode(st_ff.ctrl[QPD_CTRL_STEPDIR]),
        .channel_exchange_on(st_ff.ctrl[QPD_CTRL_SWAP]),
        .channel_a_in(channel_a_in),
        .channel_b_in(channel_b_in),
        .step(step),
        .step_reverse(step_reverse),
        .phase_error(phase_error)
    );

    qpd_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_go(wr_go),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // Index detected on its rising edge, only while enabled
    assign idx_rise = enable & index_in & !st_ff.idx_prev;

    // Event sources for the sticky status bits
    always_comb
    begin
        events = '0;
        events[QPD_IRQ_ERR] = phase_error;
        events[QPD_IRQ_DIR] = step & (step_reverse != st_ff.rev);
        events[QPD_IRQ_TMR] = velocity_timer_expired & enable;
        events[QPD_IRQ_IDX] = idx_rise;
    end

    // Read decode: every mapped word answers OKAY, others SLVERR
    always_comb
    begin
        rd_data = '0;
        rd_ok = 1'b1;
        unique case (rd_addr)
            QPD_CTRL_OFS: rd_data[QPD_CTRL_W-1:0] = st_ff.ctrl;
            QPD_LIMIT_OFS: rd_data[POS_W-1:0] = st_ff.limit;
            QPD_POS_OFS: rd_data[POS_W-1:0] = st_ff.pos;
            QPD_STAT_OFS:
            begin
                rd_data[QPD_STAT_ERR] = st_ff.err;
                rd_data[QPD_STAT_REV] = st_ff.rev;
            end
            QPD_RAW_OFS: rd_data[QPD_IRQ_W-1:0] = st_ff.raw;
            QPD_MASKED_OFS: rd_data[QPD_IRQ_W-1:0] = st_ff.raw & st_ff.mask;
            QPD_IMASK_OFS: rd_data[QPD_IRQ_W-1:0] = st_ff.mask;
            QPD_ICLR_OFS: rd_data = '0;
            default: rd_ok = 1'b0;
        endcase
    end

    assign wr_ok = (wr_addr == QPD_CTRL_OFS) | (wr_addr == QPD_LIMIT_OFS) | (wr_addr == QPD_POS_OFS)
        | (wr_addr == QPD_IMASK_OFS) | (wr_addr == QPD_ICLR_OFS);

    // Main next-state logic; hardware events win over software clears
    always_comb
    begin
        logic [QPD_DW-1:0] w;
        logic [QPD_IRQ_W-1:0] clr;
        w = '0;
        clr = '0;
        nxt_st = st_ff;
        nxt_st.idx_prev = index_in;
        nxt_st.vstep = step;
        if (wr_go)
        begin
            unique case (wr_addr)
                QPD_CTRL_OFS:
                begin
                    w = lane_merge(QPD_DW'(st_ff.ctrl), wr_data, wr_strb);
                    nxt_st.ctrl = w[QPD_CTRL_W-1:0];
                end
                QPD_LIMIT_OFS:
                begin
                    w = lane_merge(QPD_DW'(st_ff.limit), wr_data, wr_strb);
                    nxt_st.limit = w[POS_W-1:0];
                end
                QPD_POS_OFS:
                begin
                    w = lane_merge(QPD_DW'(st_ff.pos), wr_data, wr_strb);
                    nxt_st.pos = w[POS_W-1:0];
                end
                QPD_IMASK_OFS:
                begin
                    w = lane_merge(QPD_DW'(st_ff.mask), wr_data, wr_strb);
                    nxt_st.mask = w[QPD_IRQ_W-1:0];
                end
                QPD_ICLR_OFS: clr = wr_data[QPD_IRQ_W-1:0];
                default: ;
            endcase
        end
        // Position counting, index handling has priority over a step
        if (idx_rise & st_ff.ctrl[QPD_CTRL_IDXRST])
            nxt_st.pos = st_ff.rev ? st_ff.limit : '0;
        else if (step)
        begin
            if (step_reverse)
                nxt_st.pos = (st_ff.ctrl[QPD_CTRL_IDXRST] && st_ff.pos == '0) ? st_ff.limit
                    : st_ff.pos - 1'b1;
            else
                nxt_st.pos = (st_ff.ctrl[QPD_CTRL_IDXRST] && st_ff.pos >= st_ff.limit) ? '0
                    : st_ff.pos + 1'b1;
        end
        if (step)
            nxt_st.rev = step_reverse;
        if (phase_error)
            nxt_st.err = 1'b1;
        nxt_st.raw = (st_ff.raw & ~clr) | events;
        nxt_st.irq = |(nxt_st.raw & nxt_st.mask);
    end

    assign irq = st_ff.irq;
    assign velocity_step = st_ff.vstep;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    // Checks
    sequence idx_fwd_s;
        idx_rise & st_ff.ctrl[QPD_CTRL_IDXRST] & !st_ff.rev;
    endsequence
    sequence idx_rev_s;
        idx_rise & st_ff.ctrl[QPD_CTRL_IDXRST] & st_ff.rev;
    endsequence
    idx_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) idx_fwd_s |=> st_ff.pos == '0)
        else $error("index did not zero position");
    idx_limit_a: assert property (@(posedge aclk) disable iff (!aresetn) idx_rev_s |=> st_ff.pos == $past(st_ff.limit))
        else $error("reverse index did not load limit");
    idx_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (idx_rise & !st_ff.ctrl[QPD_CTRL_IDXRST] & !step & !wr_go) |=> $stable(st_ff.pos))
        else $error("index moved position while reset off");
    disabled_still_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!enable & !wr_go) |=> $stable(st_ff.pos) && $stable(st_ff.rev))
        else $error("decoder moved while disabled");
    err_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn) st_ff.err |=> st_ff.err)
        else $error("error flag dropped");
    err_set_a: assert property (@(posedge aclk) disable iff (!aresetn) phase_error |=> st_ff.err && st_ff.raw[QPD_IRQ_ERR])
        else $error("phase error not recorded");
    irq_mask_a: assert property (@(posedge aclk) disable iff (!aresetn) irq |-> |($past(nxt_st.raw) & $past(nxt_st.mask)))
        else $error("interrupt without enabled source");
    set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn) events[QPD_IRQ_IDX] |=> st_ff.raw[QPD_IRQ_IDX])
        else $error("index event lost");
    wrap_fwd_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (step & !step_reverse & st_ff.ctrl[QPD_CTRL_IDXRST] & !idx_rise & !wr_go & st_ff.pos == st_ff.limit)
        |=> st_ff.pos == '0)
        else $error("forward wrap missing");
    timer_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!enable & !st_ff.raw[QPD_IRQ_TMR]) |=> !st_ff.raw[QPD_IRQ_TMR])
        else $error("timer event while disabled");
    // Reverse wrap, direction memory and clears
    sequence rev_wrap_s;
        step & step_reverse & st_ff.ctrl[QPD_CTRL_IDXRST] & !idx_rise & !wr_go & st_ff.pos == '0;
    endsequence
    wrap_rev_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rev_wrap_s |=> st_ff.pos == $past(st_ff.limit))
        else $error("reverse wrap missing");
    dir_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        step |=> st_ff.rev == $past(step_reverse))
        else $error("direction not recorded");
    dir_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (step & (step_reverse != st_ff.rev)) |=> st_ff.raw[QPD_IRQ_DIR])
        else $error("direction change not flagged");
    clr_idx_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go & wr_addr == QPD_ICLR_OFS & wr_data[QPD_IRQ_IDX] & !idx_rise) |=> !st_ff.raw[QPD_IRQ_IDX])
        else $error("index source not cleared");
endmodule
`default_nettype wire

// ### testbench/qpd_encoder_model.sv
// Behavioural rotary encoder driving the decoder's channel and index pins.
// Assumes the bench calls its tasks from one process; pins move just after aclk rises.
`timescale 1ns/10ps
`default_nettype none
module qpd_encoder_model
(
    input wire logic aclk,
    output logic channel_a_in,
    output logic channel_b_in,
    output logic index_in
);
    int ph = 0;

    // Lines start at rest so the first sample after reset shows no edge
    initial
    begin
        channel_a_in = 1'b0;
        channel_b_in = 1'b0;
        index_in = 1'b0;
    end

    // Gray walk with A leading B forward; n of 2 flips both lines at once
    task automatic quad(input bit rev, input int n);
        ph = rev ? (ph + 4 - n) % 4 : (ph + n) % 4;
        @(posedge aclk);
        channel_a_in <= (ph == 1 || ph == 2);
        channel_b_in <= (ph >= 2);
        repeat (3) @(posedge aclk);
    endtask

    // Direction level settles before the step clock rises
    task automatic sd(input bit rev, input bit swp);
        @(posedge aclk);
        {channel_a_in, channel_b_in} <= swp ? {rev, 1'b0} : {1'b0, rev};
        repeat (2) @(posedge aclk);
        if (swp) channel_b_in <= 1'b1; else channel_a_in <= 1'b1;
        repeat (3) @(posedge aclk);
        if (swp) channel_b_in <= 1'b0; else channel_a_in <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    // Index pulse two cycles wide
    task automatic idx();
        @(posedge aclk);
        index_in <= 1'b1;
        repeat (2) @(posedge aclk);
        index_in <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// ### testbench/tb_quadrature_position_decoder.sv
// Self-checking bench for the position decoder: AXI4-Lite master, encoder model.
// Assumes the register map and field layout given by the qpd_pkg constants.
`timescale 1ns/10ps
`default_nettype none
module tb_quadrature_position_decoder
    import qpd_pkg::*;
;
    localparam logic [31:0] C_EN = 32'h1 << QPD_CTRL_EN;
    localparam logic [31:0] C_BOTH = 32'h1 << QPD_CTRL_BOTH;
    localparam logic [31:0] C_IDX = 32'h1 << QPD_CTRL_IDXRST;
    localparam logic [31:0] C_SD = 32'h1 << QPD_CTRL_STEPDIR;
    localparam logic [31:0] C_SW = 32'h1 << QPD_CTRL_SWAP;
    logic aclk = 1'b0, aresetn = 1'b0, velocity_timer_expired = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, ep, lim, r, rng = 32'h2AD46A7B;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, velocity_step;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    wire logic channel_a_in, channel_b_in, index_in;
    int err_total = 0, check_count = 0, cyc = 0, vcount = 0, v0;
    bit rev, ed, dchg;

    qpd_top #(.POS_W(32)) dut (.aclk, .aresetn, .channel_a_in, .channel_b_in, .index_in,
        .velocity_timer_expired, .velocity_step, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    qpd_encoder_model enc (.aclk, .channel_a_in, .channel_b_in, .index_in);

    always #4 aclk = ~aclk;

    // Counted on the falling edge so the registered pulse is settled
    always @(negedge aclk)
    begin
        cyc++;
        if (velocity_step === 1'b1) vcount++;
        if (cyc == 6000)
        begin
            err_total++;
            print_verdict();
        end
    end

    task print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    function logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // Expected next count; wrap only applies in index-reset mode
    function logic [31:0] np(input logic [31:0] p, input bit rv, input bit wrap);
        if (wrap) return rv ? (p == 0 ? lim : p - 1) : (p >= lim ? 32'h0 : p + 1);
        return rv ? p - 1 : p + 1;
    endfunction

    // Readies sampled mid-cycle, acted on right after the taking edge
    task wr(input logic [7:0] a, input logic [31:0] d);
        bit ha, hw, hb;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        hb = 0;
        while (!hb)
        begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask

    task rdr(input logic [7:0] a);
        bit hr, hd;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        hd = 0;
        while (!hd)
        begin
            @(negedge aclk);
            hr = s_axi_arvalid && s_axi_arready;
            hd = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (hr) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask

    task chkr(input string n, input logic [7:0] a, input logic [31:0] e);
        rdr(a);
        chk(n, rd, e);
    endtask

    task ck_irq(input logic e);
        @(negedge aclk);
        chk("irq", {31'h0, irq}, {31'h0, e});
    endtask

    // Main sequence; a limit too short ends it through the timeout
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 8; i++) chkr("reset value", 8'(i * 4), 32'h0);
        wr(8'h20, 32'h1);
        chk("unmapped write", {30'h0, rs}, {30'h0, QPD_RESP_SLVERR});
        chkr("unmapped read", 8'h24, 32'h0);
        chk("unmapped read resp", {30'h0, rs}, {30'h0, QPD_RESP_SLVERR});
        enc.quad(0, 1);
        enc.quad(0, 1);
        chkr("pos disabled", QPD_POS_OFS, 32'h0);
        chk("vel disabled", vcount, 0);
        r = xs();
        lim = 32'd5 + (r % 8);
        wr(QPD_LIMIT_OFS, lim);
        wr(QPD_IMASK_OFS, 32'hF);
        wr(QPD_CTRL_OFS, C_EN | C_BOTH);
        ep = 0;
        ed = 0;
        dchg = 0;
        for (int i = 0; i < 12; i++)
        begin
            r = xs();
            rev = (i == 5) ? 1'b1 : (i == 6) ? 1'b0 : r[0];
            if (rev != ed) dchg = 1;
            ed = rev;
            enc.quad(rev, 1);
            ep = np(ep, rev, 0);
            chkr("pos relative", QPD_POS_OFS, ep);
            chkr("direction", QPD_STAT_OFS, {30'h0, ed, 1'b0});
        end
        chk("vel count", vcount, 12);
        enc.idx();
        chkr("pos index off", QPD_POS_OFS, ep);
        chkr("raw dir idx", QPD_RAW_OFS, {28'h0, 1'b1, 1'b0, dchg, 1'b0});
        wr(QPD_IMASK_OFS, 32'h5);
        chkr("masked none", QPD_MASKED_OFS, 32'h0);
        ck_irq(1'b0);
        @(posedge aclk);
        velocity_timer_expired <= 1'b1;
        @(posedge aclk);
        velocity_timer_expired <= 1'b0;
        chkr("raw timer", QPD_RAW_OFS, 32'hE);
        chkr("masked timer", QPD_MASKED_OFS, 32'h4);
        ck_irq(1'b1);
        wr(QPD_ICLR_OFS, 32'h4);
        chkr("raw cleared", QPD_RAW_OFS, 32'hA);
        ck_irq(1'b0);
        wr(QPD_ICLR_OFS, 32'hF);
        chkr("raw all clear", QPD_RAW_OFS, 32'h0);
        wr(QPD_CTRL_OFS, C_EN | C_BOTH | C_IDX);
        wr(QPD_POS_OFS, lim);
        enc.quad(0, 1);
        chkr("wrap up", QPD_POS_OFS, np(lim, 0, 1));
        enc.quad(1, 1);
        chkr("wrap down", QPD_POS_OFS, lim);
        enc.quad(1, 1);
        enc.idx();
        chkr("index reverse", QPD_POS_OFS, lim);
        enc.quad(0, 1);
        enc.quad(0, 1);
        enc.idx();
        chkr("index forward", QPD_POS_OFS, 32'h0);
        chkr("raw index", QPD_RAW_OFS, 32'hA);
        wr(QPD_CTRL_OFS, C_EN);
        v0 = vcount;
        repeat (4) enc.quad(0, 1);
        chkr("pos first only", QPD_POS_OFS, 32'h2);
        chk("vel first only", vcount - v0, 2);
        wr(QPD_CTRL_OFS, C_EN | C_BOTH);
        enc.quad(0, 2);
        rdr(QPD_STAT_OFS);
        chk("error flag", {31'h0, rd[QPD_STAT_ERR]}, 32'h1);
        rdr(QPD_RAW_OFS);
        chk("raw error", {31'h0, rd[QPD_IRQ_ERR]}, 32'h1);
        ck_irq(1'b1);
        wr(QPD_CTRL_OFS, C_SD | C_SW);
        wr(QPD_CTRL_OFS, C_EN | C_SD | C_SW);
        wr(QPD_POS_OFS, 32'h0);
        enc.sd(0, 1);
        enc.sd(0, 1);
        chkr("step swapped", QPD_POS_OFS, 32'h2);
        enc.sd(1, 1);
        chkr("step reverse", QPD_POS_OFS, 32'h1);
        rdr(QPD_STAT_OFS);
        chk("step dir", {31'h0, rd[QPD_STAT_REV]}, 32'h1);
        wr(QPD_CTRL_OFS, C_SD);
        wr(QPD_CTRL_OFS, C_EN | C_SD);
        enc.sd(0, 0);
        chkr("step plain", QPD_POS_OFS, 32'h2);
        print_verdict();
    end
endmodule
`default_nettype wire
